// ===== msfr_pkg.sv
// msfr_pkg: constants, enums and carrier structs for the mpu special-function block
// assumes one 50 MHz clock and a synchronous active-high reset everywhere
`default_nettype none

package msfr_pkg;

    // special-function register addresses
    localparam logic [7:0] ADDR_PORT0_DATA       = 8'h80;
    localparam logic [7:0] ADDR_STACK_POINTER    = 8'h81;
    localparam logic [7:0] ADDR_DATA_PTR_LOW     = 8'h82;
    localparam logic [7:0] ADDR_DATA_PTR_HIGH    = 8'h83;
    localparam logic [7:0] ADDR_MEM_STRETCH      = 8'h8E;
    localparam logic [7:0] ADDR_PORT1_DATA       = 8'h90;
    localparam logic [7:0] ADDR_PORT1_DIRECTION  = 8'h91;
    localparam logic [7:0] ADDR_FLASH_ERASE      = 8'h94;
    localparam logic [7:0] ADDR_EEPROM_DATA      = 8'h9E;
    localparam logic [7:0] ADDR_EEPROM_CONTROL   = 8'h9F;
    localparam logic [7:0] ADDR_PORT2_DATA       = 8'hA0;
    localparam logic [7:0] ADDR_PORT2_DIRECTION  = 8'hA1;
    localparam logic [7:0] ADDR_PORT0_DIRECTION  = 8'hA2;
    localparam logic [7:0] ADDR_FLASH_CONTROL    = 8'hB2;
    localparam logic [7:0] ADDR_FLASH_BANK       = 8'hB6;
    localparam logic [7:0] ADDR_FLASH_PAGE       = 8'hB7;

    // flash control field positions
    localparam int FC_PROGRAM_WRITE_EN = 0;
    localparam int FC_MASS_ERASE_EN    = 1;
    localparam int FC_ENGINE_PROTECT   = 4;
    localparam int FC_BOOT_PROTECT     = 5;
    localparam int FC_SECURE           = 6;
    localparam int FC_PREBOOT          = 7;

    // erase trigger codes written to the erase register
    localparam logic [7:0] ERASE_CODE_MASS = 8'hAA;
    localparam logic [7:0] ERASE_CODE_PAGE = 8'h55;

    // values after reset
    localparam logic [7:0]  RESET_STACK_POINTER = 8'h07;
    localparam logic [15:0] RESET_PROGRAM_CTR   = 16'h0000;
    localparam logic [15:0] RESET_DATA_POINTER  = 16'h0000;
    localparam logic [2:0]  RESET_MEM_STRETCH   = 3'h1;
    localparam logic [7:0]  RESET_PAGE_ADDRESS  = 8'h00;
    localparam logic [7:0]  RESET_PORT_DATA     = 8'h00;
    localparam logic [7:0]  RESET_PORT_DIR      = 8'h00;

    // cycles of address setup before a strobe of an external data move
    localparam logic [2:0] ADDR_SETUP_CYCLES = 3'h1;

    // one-hot states of the external data move sequencer
    typedef enum logic [2:0] {
        MOVE_IDLE   = 3'b001,
        MOVE_ADDR   = 3'b010,
        MOVE_STROBE = 3'b100
    } msfr_move_e;

    // register access from the core, single cycle
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] address;
        logic [7:0] writeData;
    } msfr_sfr_req_s;

    // requests for one external data move
    typedef struct packed {
        logic        start;
        logic        isWrite;
        logic [7:0]  accumulator;
    } msfr_move_req_s;

    // external memory strobes
    typedef struct packed {
        logic [15:0] address;
        logic [7:0]  writeData;
        logic        addrValid;
        logic        readStrobe;
        logic        writeStrobe;
        logic        flashWrite;
        logic        done;
    } msfr_mem_bus_s;

    // flash erase commands to the flash controller
    typedef struct packed {
        logic       massErase;
        logic       pageErase;
        logic [6:0] page;
        logic [2:0] bank;
    } msfr_erase_cmd_s;

endpackage : msfr_pkg

`default_nettype wire

// ===== msfr_dio_port.sv
// msfr_dio_port: one 8-bit bidirectional port with data latch, direction and pin sampling
// assumes pin levels arrive asynchronously; the main block does the address decode
`default_nettype none

module msfr_dio_port (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // register writes from the main block
    input  wire logic       dataWrite,
    input  wire logic       dirWrite,
    input  wire logic [7:0] writeData,
    // pad side
    input  wire logic [7:0] pinIn,
    output logic      [7:0] pinOut,
    output logic      [7:0] pinOe,
    // sampled pin level and latch contents for reads
    output logic      [7:0] pinLevel,
    output logic      [7:0] latch,
    output logic      [7:0] direction
);
    import msfr_pkg::*;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] direction;
        logic [7:0] syncFirst;
        logic [7:0] syncSecond;
    } msfr_port_state_s;

    msfr_port_state_s state;
    msfr_port_state_s next_state;

    // latch and direction updates plus two-stage pin synchroniser
    always_comb begin
        next_state            = state;
        next_state.syncFirst  = pinIn;
        next_state.syncSecond = state.syncFirst;
        if (dataWrite) begin
            next_state.latch = writeData;
        end
        if (dirWrite) begin
            next_state.direction = writeData;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state.latch      <= RESET_PORT_DATA;
            state.direction  <= RESET_PORT_DIR;
            state.syncFirst  <= 8'h00;
            state.syncSecond <= 8'h00;
        end else begin
            state <= next_state;
        end
    end

    // pins follow the latch wherever the direction bit is set
    assign pinOut    = state.latch;
    assign pinOe     = state.direction;
    // the pin itself is read back even while it drives
    assign pinLevel  = state.syncSecond;
    assign latch     = state.latch;
    assign direction = state.direction;

endmodule // msfr_dio_port

`default_nettype wire

// ===== msfr_top.sv
// msfr_top: special-function registers of the mpu core, ports, stretch and flash control
// assumes the core gives single-cycle register strobes and push, pop and fetch pulses
`default_nettype none

module msfr_top (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     reset,
    // register access from the core
    input  wire msfr_pkg::msfr_sfr_req_s  sfrReq,
    output logic      [7:0]               sfrReadData,
    // core sequencing pulses
    input  wire logic                     stackPush,
    input  wire logic                     stackPop,
    input  wire logic                     codeFetch,
    input  wire logic                     pcLoad,
    input  wire logic [15:0]              pcLoadValue,
    output logic      [15:0]              programCounter,
    output logic      [7:0]               stackPointer,
    // external data moves
    input  wire msfr_pkg::msfr_move_req_s moveReq,
    output msfr_pkg::msfr_mem_bus_s       memBus,
    // flash control
    input  wire logic [6:0]               engineCodeLocation,
    input  wire logic [6:0]               bootSize,
    input  wire logic                     prebootActive,
    output msfr_pkg::msfr_erase_cmd_s     eraseCmd,
    output logic                          eraseBlocked,
    output logic                          secureActive,
    // ports
    input  wire logic [7:0]               port0PinIn,
    input  wire logic [7:0]               port1PinIn,
    input  wire logic [7:0]               port2PinIn,
    output logic      [7:0]               port0PinOut,
    output logic      [7:0]               port1PinOut,
    output logic      [7:0]               port2PinOut,
    output logic      [7:0]               port0PinOe,
    output logic      [7:0]               port1PinOe,
    output logic      [7:0]               port2PinOe
);
    import msfr_pkg::*;

    typedef struct packed {
        logic [7:0]      readData;
        logic [7:0]      stackPointer;
        logic [15:0]     programCounter;
        logic [15:0]     dataPointer;
        logic [2:0]      memStretch;
        logic [7:0]      pageAddress;
        logic [2:0]      flashBank;
        logic [7:0]      eepromData;
        logic [7:0]      eepromControl;
        logic            programWriteEn;
        logic            massEraseEn;
        logic            engineProtect;
        logic            bootProtect;
        logic            secure;
        logic            prebootFirst;
        logic            prebootSync;
        msfr_move_e      moveState;
        logic [2:0]      phaseCount;
        logic            moveIsWrite;
        logic [7:0]      moveData;
        msfr_mem_bus_s   memBus;
        msfr_erase_cmd_s eraseCmd;
        logic            eraseBlocked;
    } msfr_state_s;

    msfr_state_s state;
    msfr_state_s next_state;

    logic [7:0] port0Level;
    logic [7:0] port1Level;
    logic [7:0] port2Level;
    logic [7:0] port0Latch;
    logic [7:0] port1Latch;
    logic [7:0] port2Latch;
    logic [7:0] port0Dir;
    logic [7:0] port1Dir;
    logic [7:0] port2Dir;

    logic       wrHit;
    logic [7:0] flashControlRead;
    logic       pageInEngine;
    logic       pageInBoot;

    assign wrHit = sfrReq.write;

    // one instance per port; each decodes nothing itself
    msfr_dio_port port0Unit (
        .clock     (clock),
        .reset     (reset),
        .dataWrite (wrHit && sfrReq.address == ADDR_PORT0_DATA),
        .dirWrite  (wrHit && sfrReq.address == ADDR_PORT0_DIRECTION),
        .writeData (sfrReq.writeData),
        .pinIn     (port0PinIn),
        .pinOut    (port0PinOut),
        .pinOe     (port0PinOe),
        .pinLevel  (port0Level),
        .latch     (port0Latch),
        .direction (port0Dir)
    );

    msfr_dio_port port1Unit (
        .clock     (clock),
        .reset     (reset),
        .dataWrite (wrHit && sfrReq.address == ADDR_PORT1_DATA),
        .dirWrite  (wrHit && sfrReq.address == ADDR_PORT1_DIRECTION),
        .writeData (sfrReq.writeData),
        .pinIn     (port1PinIn),
        .pinOut    (port1PinOut),
        .pinOe     (port1PinOe),
        .pinLevel  (port1Level),
        .latch     (port1Latch),
        .direction (port1Dir)
    );

    msfr_dio_port port2Unit (
        .clock     (clock),
        .reset     (reset),
        .dataWrite (wrHit && sfrReq.address == ADDR_PORT2_DATA),
        .dirWrite  (wrHit && sfrReq.address == ADDR_PORT2_DIRECTION),
        .writeData (sfrReq.writeData),
        .pinIn     (port2PinIn),
        .pinOut    (port2PinOut),
        .pinOe     (port2PinOe),
        .pinLevel  (port2Level),
        .latch     (port2Latch),
        .direction (port2Dir)
    );

    // flash control readback; the mass erase enable is write-only and reads zero
    always_comb begin
        flashControlRead                      = 8'h00;
        flashControlRead[FC_PROGRAM_WRITE_EN] = state.programWriteEn;
        flashControlRead[FC_ENGINE_PROTECT]   = state.engineProtect;
        flashControlRead[FC_BOOT_PROTECT]     = state.bootProtect;
        flashControlRead[FC_SECURE]           = state.secure;
        flashControlRead[FC_PREBOOT]          = state.prebootSync;
    end

    // protected regions, both in 1 KB pages
    assign pageInEngine = state.pageAddress[6:0] >= engineCodeLocation;
    assign pageInBoot   = state.pageAddress[6:0] <  bootSize;

    // register writes, counters, sequencer and erase commands
    always_comb begin
        next_state                    = state;
        next_state.prebootFirst       = prebootActive;
        next_state.prebootSync        = state.prebootFirst;
        next_state.eraseCmd.massErase = 1'b0;
        next_state.eraseCmd.pageErase = 1'b0;
        next_state.eraseBlocked       = 1'b0;
        next_state.memBus.done        = 1'b0;

        // program counter: a load wins over a fetch increment
        if (pcLoad) begin
            next_state.programCounter = pcLoadValue;
        end else if (codeFetch) begin
            next_state.programCounter = state.programCounter + 16'h0001;
        end

        // stack pointer: pre-increment on push, a direct write overrides
        if (stackPush) begin
            next_state.stackPointer = state.stackPointer + 8'h01;
        end else if (stackPop) begin
            next_state.stackPointer = state.stackPointer - 8'h01;
        end

        if (sfrReq.write) begin
            unique case (sfrReq.address)
                ADDR_STACK_POINTER: begin
                    next_state.stackPointer = sfrReq.writeData;
                end
                ADDR_DATA_PTR_LOW: begin
                    next_state.dataPointer[7:0] = sfrReq.writeData;
                end
                ADDR_DATA_PTR_HIGH: begin
                    next_state.dataPointer[15:8] = sfrReq.writeData;
                end
                ADDR_MEM_STRETCH: begin
                    next_state.memStretch = sfrReq.writeData[2:0];
                end
                ADDR_EEPROM_DATA: begin
                    next_state.eepromData = sfrReq.writeData;
                end
                ADDR_EEPROM_CONTROL: begin
                    next_state.eepromControl = sfrReq.writeData;
                end
                ADDR_FLASH_BANK: begin
                    next_state.flashBank = sfrReq.writeData[2:0];
                end
                ADDR_FLASH_PAGE: begin
                    next_state.pageAddress = sfrReq.writeData;
                end
                ADDR_FLASH_CONTROL: begin
                    next_state.programWriteEn = sfrReq.writeData[FC_PROGRAM_WRITE_EN];
                    next_state.massEraseEn    = sfrReq.writeData[FC_MASS_ERASE_EN];
                    next_state.engineProtect  = sfrReq.writeData[FC_ENGINE_PROTECT];
                    next_state.bootProtect    = sfrReq.writeData[FC_BOOT_PROTECT];
                    // zero writes ignored: only reset clears it
                    next_state.secure = state.secure | sfrReq.writeData[FC_SECURE];
                end
                ADDR_FLASH_ERASE: begin
                    // enable is spent by every mass request, so each needs a fresh write
                    if (sfrReq.writeData == ERASE_CODE_MASS) begin
                        next_state.massEraseEn = 1'b0;
                        if (state.massEraseEn) begin
                            next_state.eraseCmd.massErase = 1'b1;
                        end else begin
                            next_state.eraseBlocked = 1'b1;
                        end
                    end else if (sfrReq.writeData == ERASE_CODE_PAGE) begin
                        if ((state.engineProtect && pageInEngine)
                            || (state.bootProtect && pageInBoot)) begin
                            next_state.eraseBlocked = 1'b1;
                        end else begin
                            next_state.eraseCmd.pageErase = 1'b1;
                            next_state.eraseCmd.page = state.pageAddress[6:0];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        next_state.eraseCmd.bank = state.flashBank;

        // external data move: one address setup cycle, then a strobe of stretch+1
        unique case (state.moveState)
            MOVE_IDLE: begin
                if (moveReq.start) begin
                    next_state.moveState        = MOVE_ADDR;
                    next_state.moveIsWrite      = moveReq.isWrite;
                    next_state.moveData         = moveReq.accumulator;
                    next_state.phaseCount       = ADDR_SETUP_CYCLES;
                    next_state.memBus.address   = state.dataPointer;
                    next_state.memBus.writeData = moveReq.accumulator;
                    next_state.memBus.addrValid = 1'b1;
                end
            end
            MOVE_ADDR: begin
                next_state.phaseCount = state.phaseCount - 3'h1;
                if (state.phaseCount == 3'h1) begin
                    next_state.moveState  = MOVE_STROBE;
                    next_state.phaseCount = state.memStretch;
                    // flash store only when program writes are enabled
                    next_state.memBus.flashWrite  = state.moveIsWrite
                                                    && state.programWriteEn;
                    next_state.memBus.writeStrobe = state.moveIsWrite
                                                    && !state.programWriteEn;
                    next_state.memBus.readStrobe  = !state.moveIsWrite;
                end
            end
            MOVE_STROBE: begin
                next_state.phaseCount = state.phaseCount - 3'h1;
                if (state.phaseCount == 3'h0) begin
                    next_state.moveState          = MOVE_IDLE;
                    next_state.memBus.addrValid   = 1'b0;
                    next_state.memBus.readStrobe  = 1'b0;
                    next_state.memBus.writeStrobe = 1'b0;
                    next_state.memBus.flashWrite  = 1'b0;
                    next_state.memBus.done        = 1'b1;
                end
            end
            default: begin
                next_state.moveState = MOVE_IDLE;
            end
        endcase

        // registered read data; pins are read, not the latches
        next_state.readData = 8'h00;
        if (sfrReq.read) begin
            unique case (sfrReq.address)
                ADDR_PORT0_DATA:      next_state.readData = port0Level;
                ADDR_PORT1_DATA:      next_state.readData = port1Level;
                ADDR_PORT2_DATA:      next_state.readData = port2Level;
                ADDR_PORT0_DIRECTION: next_state.readData = port0Dir;
                ADDR_PORT1_DIRECTION: next_state.readData = port1Dir;
                ADDR_PORT2_DIRECTION: next_state.readData = port2Dir;
                ADDR_STACK_POINTER:   next_state.readData = state.stackPointer;
                ADDR_DATA_PTR_LOW:    next_state.readData = state.dataPointer[7:0];
                ADDR_DATA_PTR_HIGH:   next_state.readData = state.dataPointer[15:8];
                ADDR_MEM_STRETCH:     next_state.readData = {5'h00, state.memStretch};
                ADDR_EEPROM_DATA:     next_state.readData = state.eepromData;
                ADDR_EEPROM_CONTROL:  next_state.readData = state.eepromControl;
                ADDR_FLASH_CONTROL:   next_state.readData = flashControlRead;
                ADDR_FLASH_BANK:      next_state.readData = {5'h00, state.flashBank};
                ADDR_FLASH_PAGE:      next_state.readData = state.pageAddress;
                default:              next_state.readData = 8'h00;
            endcase
        end
    end

    // single register stage; unused latch copies kept for debug visibility only
    always_ff @(posedge clock) begin
        if (reset) begin
            state                <= '0;
            state.stackPointer   <= RESET_STACK_POINTER;
            state.programCounter <= RESET_PROGRAM_CTR;
            state.dataPointer    <= RESET_DATA_POINTER;
            state.memStretch     <= RESET_MEM_STRETCH;
            state.pageAddress    <= RESET_PAGE_ADDRESS;
            state.moveState      <= MOVE_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state register
    assign sfrReadData    = state.readData;
    assign programCounter = state.programCounter;
    assign stackPointer   = state.stackPointer;
    assign memBus         = state.memBus;
    assign eraseCmd       = state.eraseCmd;
    assign eraseBlocked   = state.eraseBlocked;
    assign secureActive   = state.secure;

endmodule // msfr_top

`default_nettype wire

// ===== msfr_top_assertions.sv
// msfr_chk: concurrent checks on the special-function block, bound into msfr_top
// assumes one clock domain and a synchronous active-high reset
`default_nettype none

module msfr_chk (
    // watched ports
    input wire logic                      clock,
    input wire logic                      reset,
    input wire msfr_pkg::msfr_sfr_req_s   sfrReq,
    input wire logic                      stackPush,
    input wire logic                      codeFetch,
    input wire logic                      pcLoad,
    input wire logic [15:0]               programCounter,
    input wire logic [7:0]                stackPointer,
    input wire logic [7:0]                port0PinOut,
    input wire logic [7:0]                port0PinOe,
    input wire msfr_pkg::msfr_erase_cmd_s eraseCmd,
    input wire logic                      secureActive
);
    import msfr_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // a register write to the stack pointer wins over a push
    a_reset_values: assert property (
        $fell(reset) |-> stackPointer == 8'h07 && programCounter == 16'h0000)
        else $error("bad reset");
    a_push_increment: assert property (
        stackPush && !(sfrReq.write && sfrReq.address == ADDR_STACK_POINTER)
        |=> stackPointer == $past(stackPointer) + 8'h01) else $error("push did not increment");
    a_fetch_increment: assert property (
        codeFetch && !pcLoad |=> programCounter == $past(programCounter) + 16'h0001)
        else $error("fetch did not increment");
    a_latch_mirror: assert property (
        sfrReq.write && sfrReq.address == ADDR_PORT0_DATA
        |=> port0PinOut == $past(sfrReq.writeData))
        else $error("pin does not follow latch");
    a_direction_drive: assert property (
        sfrReq.write && sfrReq.address == ADDR_PORT0_DIRECTION
        |=> port0PinOe == $past(sfrReq.writeData))
        else $error("enable does not follow direction");
    a_secure_sticky: assert property (secureActive |=> secureActive)
        else $error("security cleared");
    a_mass_cause: assert property (
        eraseCmd.massErase |-> $past(sfrReq.write && sfrReq.address == ADDR_FLASH_ERASE
        && sfrReq.writeData == ERASE_CODE_MASS)) else $error("mass erase without trigger");
    a_page_cause: assert property (
        eraseCmd.pageErase |-> $past(sfrReq.write && sfrReq.address == ADDR_FLASH_ERASE
        && sfrReq.writeData == ERASE_CODE_PAGE)) else $error("page erase without trigger");
endmodule // msfr_chk

bind msfr_top msfr_chk chk_i (.clock(clock), .reset(reset), .sfrReq(sfrReq), .stackPush(stackPush),
    .codeFetch(codeFetch), .pcLoad(pcLoad), .programCounter(programCounter),
    .stackPointer(stackPointer), .port0PinOut(port0PinOut), .port0PinOe(port0PinOe),
    .eraseCmd(eraseCmd), .secureActive(secureActive));

`default_nettype wire

// ===== testbench.sv
// testbench: msfr_top against an integer model of its registers
// assumes msfr_pkg and the bound checker are compiled first
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import msfr_pkg::*;
    logic clock, reset, stackPush, stackPop, codeFetch, pcLoad, prebootActive, eraseBlocked, secure, b;
    logic [15:0] pcLoadValue, programCounter;
    logic [7:0] sfrReadData, stackPointer, v, c, rdv;
    logic [6:0] engLoc = 7'h0A, bootSz = 7'h04;
    logic [2:0][7:0] pIn;
    wire logic [2:0][7:0] pOut, pOe;
    logic [9:0] ev;
    msfr_sfr_req_s sfrReq;
    msfr_move_req_s moveReq;
    msfr_mem_bus_s memBus;
    msfr_erase_cmd_s eraseCmd;
    int n_errors = 0, comparisons = 0, cycles = 0, sp = 7, pc = 0, i, s, cnt;
    logic [7:0] dA [3] = '{ADDR_PORT0_DATA, ADDR_PORT1_DATA, ADDR_PORT2_DATA};
    logic [7:0] rA [3] = '{ADDR_PORT0_DIRECTION, ADDR_PORT1_DIRECTION, ADDR_PORT2_DIRECTION};
    msfr_top msfr_top_i (.clock(clock), .reset(reset), .sfrReq(sfrReq), .sfrReadData(sfrReadData),
        .stackPush(stackPush), .stackPop(stackPop), .codeFetch(codeFetch), .pcLoad(pcLoad),
        .pcLoadValue(pcLoadValue), .programCounter(programCounter), .stackPointer(stackPointer),
        .moveReq(moveReq), .memBus(memBus), .engineCodeLocation(engLoc), .bootSize(bootSz),
        .prebootActive(prebootActive), .eraseCmd(eraseCmd), .eraseBlocked(eraseBlocked),
        .secureActive(secure), .port0PinIn(pIn[0]), .port1PinIn(pIn[1]), .port2PinIn(pIn[2]),
        .port0PinOut(pOut[0]), .port1PinOut(pOut[1]), .port2PinOut(pOut[2]),
        .port0PinOe(pOe[0]), .port1PinOe(pOe[1]), .port2PinOe(pOe[2]));
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    // one register access; read data and erase outcome are sampled in the answer cycle
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        sfrReq <= '{w, !w, a, d};
        @(posedge clock);
        sfrReq <= '0;
        #1 rdv = sfrReadData;
        ev = {eraseBlocked, eraseCmd.massErase, eraseCmd.pageErase, eraseCmd.page};
        @(posedge clock);
    endtask
    task automatic close_out;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        clock = 0;
        forever #10 clock = ~clock;
    end
    // hang guard, well above the roughly 400 cycles the sequence needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        void'($urandom(32'h1fb72825));
        reset = 1;
        sfrReq = '0;
        moveReq = '0;
        {stackPush, stackPop, codeFetch, pcLoad, prebootActive} = 5'h01;
        pcLoadValue = 16'h0000;
        pIn = '0;
        repeat (12) @(posedge clock);
        reset <= 0;
        @(posedge clock);
        acc(0, ADDR_MEM_STRETCH, 0); chk(rdv, 8'h01);
        acc(0, ADDR_FLASH_PAGE, 0); chk(rdv, 8'h00);
        repeat ($urandom_range(8, 1)) begin
            stackPush <= 1;
            codeFetch <= 1;
            @(posedge clock);
            sp++;
            pc++;
        end
        {stackPush, codeFetch} <= 2'h0;
        acc(0, ADDR_STACK_POINTER, 0); chk(rdv, sp);
        chk(programCounter, pc);
        // a load beats a fetch, a pop steps the stack pointer back
        pc = $urandom_range(16'hFFFF, 0);
        pcLoadValue <= 16'(pc);
        {stackPop, pcLoad, codeFetch} <= 3'h7;
        @(posedge clock);
        {stackPop, pcLoad, codeFetch} <= 3'h0;
        @(posedge clock);
        chk(stackPointer, 16'(sp - 1));
        chk(programCounter, 16'(pc));
        for (i = 0; i < 3; i++) begin
            v = $urandom;
            acc(1, dA[i], v); acc(1, rA[i], ~v);
            chk(pOut[i], v);
            chk(pOe[i], 8'(~v));
            pIn[i] <= $urandom;
            repeat (4) @(posedge clock);
            acc(0, dA[i], 0); chk(rdv, pIn[i]);
        end
        acc(1, ADDR_DATA_PTR_LOW, 8'h34); acc(1, ADDR_DATA_PTR_HIGH, v);
        for (s = 0; s < 16; s++) begin
            acc(1, ADDR_MEM_STRETCH, 8'(s % 8)); acc(1, ADDR_FLASH_CONTROL, 8'(s / 8));
            c = 8'($urandom);
            b = s[1];   // reads on some stretch values, writes on the rest
            moveReq <= '{1'b1, b, c};
            @(posedge clock);
            moveReq <= '0;
            cnt = 0;
            repeat (14) begin
                @(posedge clock);
                #1 if (memBus.done) break;
                if (memBus.addrValid && memBus.readStrobe === !b
                    && memBus.writeStrobe === (b && s < 8) && memBus.flashWrite === (b && s >= 8))
                    cnt++;
                chk(memBus.address, {v, 8'h34});
                chk(memBus.writeData, c);
            end
            chk(memBus.done, 1'b1);
            chk(cnt, s % 8 + 1);
            @(posedge clock);
        end
        acc(1, ADDR_FLASH_ERASE, ERASE_CODE_MASS); chk(ev[9:7], 3'b100);
        acc(1, ADDR_FLASH_CONTROL, 8'h02); acc(1, ADDR_FLASH_ERASE, ERASE_CODE_MASS);
        chk(ev[9:7], 3'b010);
        acc(1, ADDR_FLASH_ERASE, ERASE_CODE_MASS); chk(ev[9:7], 3'b100);
        for (i = 0; i < 16; i++) begin
            v = $urandom_range(12, 2);
            c = 8'($urandom) & 8'h30;
            b = (c[4] && v >= engLoc) || (c[5] && v < bootSz);
            acc(1, ADDR_FLASH_CONTROL, c); acc(1, ADDR_FLASH_PAGE, v);
            acc(1, ADDR_FLASH_ERASE, ERASE_CODE_PAGE);
            chk(ev[9:7], {b, 1'b0, !b});
            if (!b) chk(ev[6:0], v[6:0]);
        end
        acc(1, ADDR_FLASH_BANK, 8'h05); acc(0, ADDR_FLASH_BANK, 0); chk(rdv, 8'h05);
        chk(eraseCmd.bank, 3'h5);
        acc(1, ADDR_EEPROM_DATA, c); acc(0, ADDR_EEPROM_DATA, 0); chk(rdv, c);
        acc(1, 8'hC3, 8'hFF); acc(0, 8'hC3, 0); chk(rdv, 8'h00);
        acc(1, ADDR_FLASH_CONTROL, 8'h40); acc(1, ADDR_FLASH_CONTROL, 8'h00);
        acc(0, ADDR_FLASH_CONTROL, 0); chk(rdv, 8'hC0);
        chk(secure, 1'b1);
        // preboot ends: status bit must drop after the synchroniser
        prebootActive <= 0;
        repeat (3) @(posedge clock);
        acc(0, ADDR_FLASH_CONTROL, 0); chk(rdv, 8'h40);
        close_out();
    end
endmodule // testbench
`default_nettype wire
